// >>> core_model.sv
// Core-side model that issues table operations
`timescale 1ns/1ps
`default_nettype none
module core_model
    import table_access_pkg::*;
(
    // Clock
    input wire logic i_clk_sys,
    // Requests
    output logic o_page_we,
    output logic [PAGE_W-1:0] o_page_wdata,
    output logic o_op_valid,
    output var table_access_pkg::table_op_e o_op,
    output logic o_byte_mode,
    output logic [DATA_W-1:0] o_ea,
    output logic [DATA_W-1:0] o_wdata,
    // Answers
    input wire logic i_rd_valid,
    input wire logic [DATA_W-1:0] i_rd_data,
    input wire logic i_wr_done,
    input wire logic i_wr_blocked,
    input wire logic i_busy
);
    // Idle request lines at time zero
    initial begin
        o_page_we = 1'b0;
        o_page_wdata = 8'h5a;
        o_op_valid = 1'b0;
        o_op = OP_READ_LOW;
        o_byte_mode = 1'b0;
        o_ea = 16'h5555;
        o_wdata = 16'haaaa;
    end

    // One-cycle page load; data inverted once released
    task automatic load_page(input logic [PAGE_W-1:0] pg);
        @(posedge i_clk_sys);
        #1;
        o_page_we = 1'b1;
        o_page_wdata = pg;
        @(posedge i_clk_sys);
        #1;
        o_page_we = 1'b0;
        o_page_wdata = ~pg;
    endtask : load_page

    // One operation; ok is low if the answer misses its cycle
    task automatic table_op(input table_op_e op, input logic bm,
            input logic [DATA_W-1:0] ea, input logic [DATA_W-1:0] wd,
            output logic [DATA_W-1:0] rd, output logic blk, output logic ok);
        rd = DATA_RST;
        blk = 1'b0;
        @(posedge i_clk_sys);
        #1;
        o_op_valid = 1'b1;
        o_op = op;
        o_byte_mode = bm;
        o_ea = ea;
        o_wdata = wd;
        @(posedge i_clk_sys);
        #1;
        // Released lines show stale-looking garbage, not the last value
        o_op_valid = 1'b0;
        o_ea = ~ea;
        o_wdata = ~wd;
        ok = i_wr_done;
        blk = i_wr_blocked;
        if (op == OP_READ_LOW || op == OP_READ_HIGH) begin
            // Read result is due exactly one edge after the take
            @(posedge i_clk_sys);
            #1;
            ok = i_rd_valid;
            rd = i_rd_data;
        end
    endtask : table_op

    // Word read, then a write held into its busy cycle; the write must vanish
    task automatic read_then_poke(input logic [DATA_W-1:0] ea, input logic [DATA_W-1:0] wd,
            output logic [DATA_W-1:0] rd, output logic bsy, output logic ok);
        @(posedge i_clk_sys);
        #1;
        o_op_valid = 1'b1;
        o_op = OP_READ_LOW;
        o_byte_mode = 1'b0;
        o_ea = ea;
        @(posedge i_clk_sys);
        #1;
        // Read taken; the block is busy and must ignore this write
        bsy = i_busy;
        o_op = OP_WRITE_LOW;
        o_wdata = wd;
        @(posedge i_clk_sys);
        #1;
        o_op_valid = 1'b0;
        o_ea = ~ea;
        o_wdata = ~wd;
        ok = i_rd_valid && !i_wr_done;
        rd = i_rd_data;
    endtask : read_then_poke
endmodule : core_model
`default_nettype wire

// >>> prog_word_mem.sv
// Small program word store with per-part write enables and registered read
`timescale 1ns/1ps
`default_nettype none
module prog_word_mem
    import table_access_pkg::*;
(
    // Clock
    input wire logic i_clk_sys,
    // Access
    input wire logic [MEM_AW-1:0] i_addr,
    input wire logic [2:0] i_byte_we,
    input wire logic [PROG_W-1:0] i_wdata,
    output logic [PROG_W-1:0] o_rdata
);
    // Storage array, no reset: contents are data, not control
    logic [PROG_W-1:0] mem [MEM_DEPTH];

    // Write selected byte lanes, read out through a register
    always_ff @(posedge i_clk_sys) begin
        for (int b = 0; b < LANE_N; b++) begin
            if (i_byte_we[b]) begin
                mem[i_addr][b*BYTE_W +: BYTE_W] <= i_wdata[b*BYTE_W +: BYTE_W];
            end
        end
        o_rdata <= mem[i_addr];
    end
endmodule : prog_word_mem
`default_nettype wire

// >>> program_space_table_access.sv
// Table read/write data path between core and program space
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Program address steps two per 24-bit word
// - Low ops hit low word, high ops upper byte
// - Word low read returns P<15:0> unchanged
// - Byte low read picks byte by select
// - Word high read returns P<23:16>, top zero
// - Byte high read returns zero for phantom byte
// - Page register bit 7 selects configuration space
// - Writes into configuration space are dropped
// - Every table op supports byte or word size
module program_space_table_access
    import table_access_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Page register load from the core
    input wire logic i_page_we,
    input wire logic [PAGE_W-1:0] i_page_wdata,
    // Table operation request
    input wire logic i_op_valid,
    input wire table_access_pkg::table_op_e i_op,
    input wire logic i_byte_mode,
    input wire logic [DATA_W-1:0] i_ea,
    input wire logic [DATA_W-1:0] i_wdata,
    // Answer to the core
    output logic o_busy,
    output logic o_rd_valid,
    output logic [DATA_W-1:0] o_rd_data,
    output logic o_wr_done,
    output logic o_wr_blocked,
    output logic [PAGE_W-1:0] o_page
);
    import table_access_pkg::*;

    // Registered state
    seq_state_e state, next_state;
    logic [PAGE_W-1:0] page, next_page;        // Table page register
    table_op_e op_q, next_op_q;                 // Captured read op
    logic byte_q, next_byte_q;                  // Captured byte mode
    logic bsel_q, next_bsel_q;                  // Captured byte select
    logic cfg_q, next_cfg_q;                    // Captured space flag
    logic [DATA_W-1:0] rd_data, next_rd_data;
    logic rd_valid, next_rd_valid;
    logic wr_done, next_wr_done;
    logic wr_blocked, next_wr_blocked;
    logic busy, next_busy;                      // Read in flight, a flop for the port

    // Address decode and memory interface
    logic [FADDR_W-1:0] full_addr;              // Page over word address
    logic bsel;                                 // EA LSB
    logic is_write;
    logic in_cfg;
    logic [LANE_N-1:0] byte_we;
    logic [PROG_W-1:0] wword;
    logic [PROG_W-1:0] mem_rdata;
    logic [BYTE_W-1:0] sel_low_byte;

    // Word address skips the LSB, so consecutive words sit two apart
    assign full_addr = {page, i_ea[DATA_W-1:BSEL_BIT+1]};
    assign bsel = i_ea[BSEL_BIT];
    assign in_cfg = page[PAGE_CFG_BIT];
    assign is_write = (i_op == OP_WRITE_LOW) || (i_op == OP_WRITE_HIGH);

    // Write lanes; configuration space never accepts a write
    always_comb begin
        byte_we = LANE_NONE;
        wword = {i_wdata[BYTE_W-1:0], i_wdata};
        if (i_op_valid && (state == ST_IDLE) && is_write && !in_cfg) begin
            if (i_op == OP_WRITE_LOW) begin
                if (!i_byte_mode) begin
                    byte_we = LANE_WORD;
                end else if (bsel) begin
                    byte_we = LANE_MID;
                    wword[2*BYTE_W-1:BYTE_W] = i_wdata[BYTE_W-1:0];
                end else begin
                    byte_we = LANE_LOW;
                end
            end else begin
                // Phantom byte write is simply discarded
                if (!i_byte_mode || !bsel) begin
                    byte_we = LANE_TOP;
                end
            end
        end
    end

    // Only one store here; only the space flag picks the region, folded in
    // above the low word-address bits, a trade of depth for simulation speed
    prog_word_mem u_mem (
        .i_clk_sys(i_clk_sys),
        .i_addr({in_cfg, full_addr[MEM_AW-2:0]}),
        .i_byte_we(byte_we),
        .i_wdata(wword),
        .o_rdata(mem_rdata)
    );

    // Byte select within the low word
    assign sel_low_byte = bsel_q ? mem_rdata[LOW_MSB:BYTE_W] : mem_rdata[BYTE_W-1:LOW_LSB];

    // Next-state logic for sequencer, page and answer
    always_comb begin
        next_state = state;
        next_page = page;
        next_op_q = op_q;
        next_byte_q = byte_q;
        next_bsel_q = bsel_q;
        next_cfg_q = cfg_q;
        next_rd_data = rd_data;
        next_rd_valid = 1'b0;
        next_wr_done = 1'b0;
        next_wr_blocked = 1'b0;
        case (state)
            ST_IDLE: begin
                // Page load only while idle, so an op sees a stable page
                if (i_page_we && !i_op_valid) begin
                    next_page = i_page_wdata;
                end
                if (i_op_valid) begin
                    if (is_write) begin
                        next_wr_done = 1'b1;
                        next_wr_blocked = in_cfg;
                    end else begin
                        next_state = ST_READ;
                        next_op_q = i_op;
                        next_byte_q = i_byte_mode;
                        next_bsel_q = bsel;
                        next_cfg_q = in_cfg;
                    end
                end
            end
            ST_READ: begin
                // Memory data is registered; shape it this cycle
                next_state = ST_DONE;
                next_rd_valid = 1'b1;
                if (op_q == OP_READ_LOW) begin
                    if (!byte_q) begin
                        next_rd_data = mem_rdata[LOW_MSB:LOW_LSB];
                    end else begin
                        next_rd_data = {ZERO_BYTE, sel_low_byte};
                    end
                end else begin
                    if (!byte_q || !bsel_q) begin
                        next_rd_data = {ZERO_BYTE, mem_rdata[HIGH_MSB:HIGH_LSB]};
                    end else begin
                        next_rd_data = DATA_RST;
                    end
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // Busy follows the next state so the port comes from a flop
        next_busy = (next_state != ST_IDLE);
    end

    // Register stage
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state <= ST_IDLE;
            page <= PAGE_RST;
            op_q <= OP_READ_LOW;
            byte_q <= 1'b0;
            bsel_q <= 1'b0;
            cfg_q <= 1'b0;
            rd_data <= DATA_RST;
            rd_valid <= 1'b0;
            wr_done <= 1'b0;
            wr_blocked <= 1'b0;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            page <= next_page;
            op_q <= next_op_q;
            byte_q <= next_byte_q;
            bsel_q <= next_bsel_q;
            cfg_q <= next_cfg_q;
            rd_data <= next_rd_data;
            rd_valid <= next_rd_valid;
            wr_done <= next_wr_done;
            wr_blocked <= next_wr_blocked;
            busy <= next_busy;
        end
    end

    // Outputs straight from flip-flops
    assign o_busy = busy;
    assign o_rd_valid = rd_valid;
    assign o_rd_data = rd_data;
    assign o_wr_done = wr_done;
    assign o_wr_blocked = wr_blocked;
    assign o_page = page;

    // Checks
    a_read_latency: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_op_valid && !o_busy && !is_write) |-> ##2 o_rd_valid)
        else $error("read answer not two cycles after request");
    a_low_word: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (state == ST_READ && op_q == OP_READ_LOW && !byte_q)
        |=> (o_rd_data == $past(mem_rdata[LOW_MSB:LOW_LSB])))
        else $error("word low read altered data");
    a_low_byte: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (state == ST_READ && op_q == OP_READ_LOW && byte_q)
        |=> (o_rd_data[DATA_W-1:BYTE_W] == ZERO_BYTE)
            && (o_rd_data[BYTE_W-1:0] == $past(sel_low_byte)))
        else $error("byte low read wrong byte");
    a_high_phantom: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (o_rd_valid && op_q == OP_READ_HIGH) |-> (o_rd_data[DATA_W-1:BYTE_W] == ZERO_BYTE))
        else $error("phantom byte not zero");
    a_high_sel: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (o_rd_valid && op_q == OP_READ_HIGH && byte_q && bsel_q) |-> (o_rd_data == DATA_RST))
        else $error("phantom byte select not zero");
    a_cfg_nowrite: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (in_cfg) |-> (byte_we == LANE_NONE))
        else $error("write reached configuration space");
    a_cfg_flag: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_op_valid && !o_busy && is_write) |=> (o_wr_done && o_wr_blocked == $past(page[PAGE_CFG_BIT])))
        else $error("write blocked flag mismatch");
    a_byte_lane: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_op_valid && !o_busy && i_op == OP_WRITE_LOW && i_byte_mode && !in_cfg)
        |-> ($countones(byte_we) == 1))
        else $error("byte write hit more than one lane");
    a_addr_map: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (full_addr[WADDR_W-1:0] == i_ea[DATA_W-1:1]) && (full_addr[FADDR_W-1:WADDR_W] == page))
        else $error("address formation wrong");
endmodule : program_space_table_access
`default_nettype wire

// >>> table_access_pkg.sv
// Constants and types shared by the program space table access block
package table_access_pkg;
    // Program word layout: 24 bits, low word plus upper byte
    localparam int PROG_W = 24;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int LOW_LSB = 0;
    localparam int LOW_MSB = 15;
    localparam int HIGH_LSB = 16;
    localparam int HIGH_MSB = 23;
    // Table page register width and configuration-space flag bit
    localparam int PAGE_W = 8;
    localparam int PAGE_CFG_BIT = 7;
    // Word address width inside one page (EA without byte select)
    localparam int WADDR_W = 15;
    // Full word address: page above the word part of the EA
    localparam int FADDR_W = PAGE_W + WADDR_W;
    // Backing store size, kept small for simulation
    localparam int MEM_AW = 8;
    localparam int MEM_DEPTH = 256;
    // Reset values
    localparam logic [PAGE_W-1:0] PAGE_RST = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;
    // Memory byte lanes: bit 0 low byte, bit 1 middle byte, bit 2 upper byte
    localparam int LANE_N = 3;
    localparam logic [LANE_N-1:0] LANE_NONE = 3'h0;
    localparam logic [LANE_N-1:0] LANE_WORD = 3'h3;
    localparam logic [LANE_N-1:0] LANE_MID = 3'h2;
    localparam logic [LANE_N-1:0] LANE_LOW = 3'h1;
    localparam logic [LANE_N-1:0] LANE_TOP = 3'h4;
    // Byte select position in the effective address
    localparam int BSEL_BIT = 0;
    // Table operation codes
    typedef enum logic [1:0] {
        OP_READ_LOW = 2'h0,
        OP_READ_HIGH = 2'h1,
        OP_WRITE_LOW = 2'h2,
        OP_WRITE_HIGH = 2'h3
    } table_op_e;
    // Sequencer states, Gray coded along idle -> read -> done
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_DONE = 2'b11
    } seq_state_e;
endpackage : table_access_pkg

// >>> tb.sv
// Self-checking testbench for the table access block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import table_access_pkg::*;
    // Clock, reset and wiring
    logic i_clk_sys;
    logic i_rst;
    logic pwe, opv, bm, busy, rv, wd, wb;
    logic [PAGE_W-1:0] pwd, pg;
    table_op_e op;
    logic [DATA_W-1:0] ea, wdat, rdat;
    // Tallies
    int n_errors;
    int n_checks;

    core_model u_core (.i_clk_sys(i_clk_sys), .o_page_we(pwe), .o_page_wdata(pwd),
        .o_op_valid(opv), .o_op(op), .o_byte_mode(bm), .o_ea(ea), .o_wdata(wdat),
        .i_rd_valid(rv), .i_rd_data(rdat), .i_wr_done(wd), .i_wr_blocked(wb),
        .i_busy(busy));
    program_space_table_access u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_page_we(pwe), .i_page_wdata(pwd), .i_op_valid(opv), .i_op(op),
        .i_byte_mode(bm), .i_ea(ea), .i_wdata(wdat), .o_busy(busy), .o_rd_valid(rv),
        .o_rd_data(rdat), .o_wr_done(wd), .o_wr_blocked(wb), .o_page(pg));

    // 125 MHz clock
    initial begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end

    // Compare data words
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Compare flags
    task automatic chkb(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkb

    // Write; done must pulse, blocked as expected
    task automatic wr(input table_op_e o, input logic b, input logic [15:0] a,
            input logic [15:0] d, input logic eb);
        logic [15:0] r;
        logic k;
        logic f;
        u_core.table_op(o, b, a, d, r, f, k);
        chkb(k, 1'b1);
        chkb(f, eb);
    endtask : wr

    // Read; result must arrive on time with the expected value
    task automatic rd(input table_op_e o, input logic b, input logic [15:0] a,
            input logic [15:0] e);
        logic [15:0] r;
        logic k;
        logic f;
        u_core.table_op(o, b, a, 16'h0000, r, f, k);
        chkb(k, 1'b1);
        chkb(f, 1'b0);
        chk(r, e);
    endtask : rd

    // Quiet outputs straight after reset
    task automatic test_reset;
        chkb(busy, 1'b0);
        chkb(rv, 1'b0);
        chkb(wd | wb, 1'b0);
        chk(rdat, 16'h0000);
        chk({8'h00, pg}, 16'h0000);
        $display("test reset done");
    endtask : test_reset

    // Word writes and reads, neighbouring words kept apart
    task automatic test_word;
        wr(OP_WRITE_LOW, 1'b0, 16'h0010, 16'ha55a, 1'b0);
        wr(OP_WRITE_HIGH, 1'b0, 16'h0010, 16'h1234, 1'b0);
        wr(OP_WRITE_LOW, 1'b0, 16'h0012, 16'h0f0f, 1'b0);
        rd(OP_READ_LOW, 1'b0, 16'h0010, 16'ha55a);
        rd(OP_READ_HIGH, 1'b0, 16'h0010, 16'h0034);
        rd(OP_READ_LOW, 1'b0, 16'h0012, 16'h0f0f);
        $display("test word done");
    endtask : test_word

    // A write issued while a read is in flight is ignored
    task automatic test_busy;
        logic [15:0] r;
        logic k;
        logic b;
        u_core.read_then_poke(16'h0012, 16'hbeef, r, b, k);
        chkb(b, 1'b1);
        chkb(k, 1'b1);
        chk(r, 16'h0f0f);
        rd(OP_READ_LOW, 1'b0, 16'h0012, 16'h0f0f);
        $display("test busy done");
    endtask : test_busy

    // Byte reads and writes on both selects
    task automatic test_byte;
        rd(OP_READ_LOW, 1'b1, 16'h0010, 16'h005a);
        rd(OP_READ_LOW, 1'b1, 16'h0011, 16'h00a5);
        rd(OP_READ_HIGH, 1'b1, 16'h0010, 16'h0034);
        rd(OP_READ_HIGH, 1'b1, 16'h0011, 16'h0000);
        wr(OP_WRITE_LOW, 1'b1, 16'h0011, 16'h00c3, 1'b0);
        wr(OP_WRITE_LOW, 1'b1, 16'h0010, 16'h0096, 1'b0);
        rd(OP_READ_LOW, 1'b0, 16'h0010, 16'hc396);
        wr(OP_WRITE_HIGH, 1'b1, 16'h0010, 16'h0077, 1'b0);
        wr(OP_WRITE_HIGH, 1'b1, 16'h0011, 16'h00ee, 1'b0);
        rd(OP_READ_HIGH, 1'b0, 16'h0010, 16'h0077);
        $display("test byte done");
    endtask : test_byte

    // Configuration page refuses writes
    task automatic test_cfg;
        u_core.load_page(8'h80);
        chk({8'h00, pg}, 16'h0080);
        wr(OP_WRITE_LOW, 1'b0, 16'h0010, 16'hdead, 1'b1);
        wr(OP_WRITE_HIGH, 1'b1, 16'h0010, 16'h0011, 1'b1);
        u_core.load_page(8'h00);
        rd(OP_READ_LOW, 1'b0, 16'h0010, 16'hc396);
        rd(OP_READ_HIGH, 1'b0, 16'h0010, 16'h0077);
        $display("test cfg done");
    endtask : test_cfg

    // Counts and verdict, then stop
    task automatic end_of_test;
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // Main sequence
    initial begin
        n_errors = 0;
        n_checks = 0;
        i_rst = 1'b1;
        repeat (8) @(posedge i_clk_sys);
        #1;
        i_rst = 1'b0;
        test_reset;
        test_word;
        test_busy;
        test_byte;
        test_cfg;
        end_of_test;
    end
endmodule : tb
`default_nettype wire
